// ### logic/ifs_supervisor.sv
/*
 * Inverter fault supervisor: leg gating, fault flags, warning
 * qualification, core state machine, status LEDs, Wishbone registers.
 * Assumes measurement words and PWM commands on clk_i; fan tachometers,
 * interlock, sensor presence and clear button come from pins.
 */
// Chosen here: the register addresses and register access over Wishbone.
// What this block does
// RL1 - both gates on together is forbidden
// RL2 - on fault, block gates and flag
// RL3 - fault above 850 V, 55 A, 80 C
// RL4 - desaturation above 2.8 V while on
// RL5 - fault when 5 V or 12 V rail leaves window
// RL6 - fault on lost fan tachometer
// RL7 - enclosure over 120 C or sensor missing
// RL8 - interlock input raises a fault
// RL9 - all flags merge into one global fault
// RL10 - latched fault clears on reset or button
// RL11 - still active fault stays on clear
// RL12 - estimate fsw, check derating limits
// RL13 - damping current above 4 A / 1.4 A
// RL14 - area faults readable by software directly
// RL15 - errors block gates with no delay
// RL16 - warnings must persist one second first
// RL17 - warning-caused faults shown in orange
// RL18 - error enters fault; clear returns blocked
// RL19 - blocked holds gates; enable goes running
// RL20 - running drives gates from commands
// RL21 - leg LEDs per module, together for converter
// RL22 - system LED shows core state or sync
// RL23 - global fault blocks gates same cycle
`timescale 1ns/1ps
`default_nettype none
`include "ifs_consts.svh"

module ifs_supervisor #(
  parameter int unsigned WARN_CYC = `IFS_WARN_CYC,
  parameter int unsigned TACH_CYC = `IFS_TACH_CYC,
  parameter int unsigned FSW_CYC = `IFS_FSW_CYC,
  parameter int unsigned SLOW_CYC = `IFS_SLOW_CYC,
  parameter int unsigned FAST_CYC = `IFS_FAST_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // gating
  input wire logic [2:0] pwm_h_i,
  input wire logic [2:0] pwm_l_i,
  output logic [2:0] gate_h_o,
  output logic [2:0] gate_l_o,
  // measurements
  input wire ifs_pkg::ifs_leg_meas_s [2:0] meas_i,
  input wire logic [15:0] enc_temp_i,
  input wire logic signed [15:0] idr_dm_i,
  input wire logic [15:0] idr_cm_rms_i,
  // pins
  input wire logic [3:0] tach_i,
  input wire logic sensor_present_i,
  input wire logic interlock_fault_i,
  input wire logic clear_btn_i,
  // controller side
  input wire logic code_running_i,
  input wire ifs_pkg::ifs_led_s sync_led_i,
  output logic global_fault_o,
  // front panel
  output ifs_pkg::ifs_led_s [2:0] leg_led_o,
  output ifs_pkg::ifs_led_s sys_led_o
);
  import ifs_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pin_meta_q, pin_sync_q, pin_last_q;
  logic [6:0] pin_meta_d, pin_sync_d, pin_last_d;
  logic [3:0] tach_s, tach_edge;
  logic sens_s, ilk_s, clr_p;

  always_comb begin
    pin_meta_d = {clear_btn_i, interlock_fault_i, sensor_present_i, tach_i};
    pin_sync_d = pin_meta_q;
    pin_last_d = pin_sync_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 7'h00;
      pin_sync_q <= 7'h00;
      pin_last_q <= 7'h00;
    end else if (ce_i) begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      pin_last_q <= pin_last_d;
    end
  end

  assign tach_s = pin_sync_q[3:0];
  assign tach_edge = tach_s & ~pin_last_q[3:0];
  assign sens_s = pin_sync_q[4];
  assign ilk_s = pin_sync_q[5];
  assign clr_p = pin_sync_q[6] & ~pin_last_q[6];

  // ----------------------------------------------------------------
  // fan tachometer watchdogs
  // ----------------------------------------------------------------
  logic [3:0] fan_lost;

  generate
    for (genvar f = 0; f < 4; f++) begin : g_tach
      logic [31:0] cnt_q, cnt_d;
      always_comb begin
        cnt_d = cnt_q;
        if (tach_edge[f]) begin
          cnt_d = 32'h0000_0000;
        end else if (cnt_q < TACH_CYC) begin
          cnt_d = cnt_q + 32'h0000_0001;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q <= 32'h0000_0000;
        end else if (ce_i) begin
          cnt_q <= cnt_d;
        end
      end
      assign fan_lost[f] = (cnt_q >= TACH_CYC); // RL6
    end
  endgenerate

  // ----------------------------------------------------------------
  // switching frequency estimate (edges per millisecond = kHz)
  // ----------------------------------------------------------------
  logic [31:0] win_q, win_d;
  logic [15:0] edges_q, edges_d, fsw_q, fsw_d;
  logic pwm_last_q, pwm_last_d;

  always_comb begin
    pwm_last_d = pwm_h_i[0];
    win_d = win_q + 32'h0000_0001;
    edges_d = edges_q;
    fsw_d = fsw_q;
    if (pwm_h_i[0] && !pwm_last_q) begin
      edges_d = edges_q + 16'h0001;
    end
    if (win_q >= FSW_CYC - 1) begin
      win_d = 32'h0000_0000;
      fsw_d = edges_d; // RL12
      edges_d = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= 32'h0000_0000;
      edges_q <= 16'h0000;
      fsw_q <= 16'h0000;
      pwm_last_q <= 1'b0;
    end else if (ce_i) begin
      win_q <= win_d;
      edges_q <= edges_d;
      fsw_q <= fsw_d;
      pwm_last_q <= pwm_last_d;
    end
  end

  // ----------------------------------------------------------------
  // raw fault conditions
  // ----------------------------------------------------------------
  logic [`IFS_NFLT-1:0] raw, eff;
  logic [15:0] imax_lo_q, imax_hi_q, vdcmax_lo_q, vdcmax_hi_q;
  logic [15:0] imax_now, vdcmax_now, idm_abs;
  logic [2:0] derate_oc;

  assign imax_now = (fsw_q < `IFS_FSW_KNEE) ? imax_lo_q : imax_hi_q;
  assign vdcmax_now = (fsw_q < `IFS_FSW_KNEE) ? vdcmax_lo_q : vdcmax_hi_q;
  assign idm_abs = idr_dm_i[15] ? 16'(-idr_dm_i) : 16'(idr_dm_i);

  generate
    for (genvar l = 0; l < 3; l++) begin : g_leg
      logic [15:0] im_abs;
      localparam int B = l * `IFS_LEG_W;
      assign im_abs = meas_i[l].im[15] ? 16'(-meas_i[l].im) : 16'(meas_i[l].im);
      assign raw[B + `IFS_F_OV] = meas_i[l].vdc > `IFS_VDC_MAX; // RL3
      assign raw[B + `IFS_F_OC] = im_abs > `IFS_IM_MAX; // RL3
      assign raw[B + `IFS_F_DESAT] = (pwm_h_i[l] && meas_i[l].vds_h > `IFS_VDS_MAX) ||
                                     (pwm_l_i[l] && meas_i[l].vds_l > `IFS_VDS_MAX); // RL4
      assign raw[B + `IFS_F_SUP] = meas_i[l].v5 < `IFS_V5_MIN ||
                                   meas_i[l].v5 > `IFS_V5_MAX ||
                                   meas_i[l].v12 < `IFS_V12_MIN ||
                                   meas_i[l].v12 > `IFS_V12_MAX; // RL5
      assign raw[B + `IFS_F_OT] = meas_i[l].temp > `IFS_TEMP_MAX; // RL3
      assign raw[B + `IFS_F_FAN] = fan_lost[l]; // RL6
      assign raw[B + `IFS_F_SHOOT] = pwm_h_i[l] & pwm_l_i[l]; // RL1
      assign derate_oc[l] = im_abs > imax_now;
    end
  endgenerate

  assign raw[`IFS_F_ENC + 0] = enc_temp_i > `IFS_ENC_TEMP_MAX; // RL7
  assign raw[`IFS_F_ENC + 1] = ~sens_s; // RL7
  assign raw[`IFS_F_ENC + 2] = fan_lost[3]; // RL6
  assign raw[`IFS_F_ENC + 3] = ilk_s; // RL8
  assign raw[`IFS_F_SOA + 0] = |derate_oc; // RL12
  assign raw[`IFS_F_SOA + 1] = meas_i[0].vdc > vdcmax_now; // RL12
  assign raw[`IFS_F_SOA + 2] = idm_abs > `IFS_IDM_MAX; // RL13
  assign raw[`IFS_F_SOA + 3] = idr_cm_rms_i > `IFS_ICM_MAX; // RL13

  // ----------------------------------------------------------------
  // warning qualification and latching
  // ----------------------------------------------------------------
  localparam logic [`IFS_NFLT-1:0] WARN = `IFS_WARN_MASK;

  generate
    for (genvar i = 0; i < `IFS_NFLT; i++) begin : g_qual
      if (WARN[i]) begin : g_warn
        logic [31:0] hold_q, hold_d;
        always_comb begin
          hold_d = 32'h0000_0000;
          if (raw[i]) begin
            hold_d = (hold_q < WARN_CYC) ? hold_q + 32'h0000_0001 : hold_q;
          end
        end
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            hold_q <= 32'h0000_0000;
          end else if (ce_i) begin
            hold_q <= hold_d;
          end
        end
        assign eff[i] = raw[i] && hold_q >= WARN_CYC - 1; // RL16
      end else begin : g_err
        assign eff[i] = raw[i]; // RL15
      end
    end
  endgenerate

  logic [`IFS_NFLT-1:0] lat_q, lat_d;
  logic glob_now;

  // a still-present condition re-sets its bit, so set wins over clear
  always_comb begin
    lat_d = eff | (lat_q & {`IFS_NFLT{~clr_p}}); // RL10 RL11
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_q <= '0;
    end else if (ce_i) begin
      lat_q <= lat_d;
    end
  end

  assign glob_now = |eff | |lat_q; // RL9
  assign global_fault_o = glob_now;

  // ----------------------------------------------------------------
  // core state machine and gating
  // ----------------------------------------------------------------
  ifs_state_e state_q, state_d;
  logic en_q, en_d, syncsel_q, syncsel_d;
  logic wr_ctrl, blocked;

  always_comb begin
    state_d = state_q;
    case (state_q)
      IFS_BLOCKED: begin
        if (glob_now) begin
          state_d = IFS_FAULT; // RL23
        end else if (en_q) begin
          state_d = IFS_RUNNING; // RL19
        end
      end
      IFS_RUNNING: begin
        if (glob_now) begin
          state_d = IFS_FAULT; // RL18 RL23
        end else if (!en_q) begin
          state_d = IFS_BLOCKED;
        end
      end
      IFS_FAULT: begin
        if (clr_p && !(|eff)) begin
          state_d = IFS_BLOCKED; // RL18 RL11
        end
      end
      default: state_d = IFS_FAULT;
    endcase
  end

  // enable is dropped on a fault so leaving the fault never restarts pwm
  always_comb begin
    en_d = en_q;
    syncsel_d = syncsel_q;
    if (wr_ctrl && sel_i[0]) begin
      en_d = dat_i[`IFS_CTRL_EN];
      syncsel_d = dat_i[`IFS_CTRL_SYNCSEL];
    end
    if (glob_now || state_q == IFS_FAULT) begin
      en_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= IFS_BLOCKED;
      en_q <= 1'b0;
      syncsel_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      en_q <= en_d;
      syncsel_q <= syncsel_d;
    end
  end

  // combinational so an error blocks the gates in the cycle it appears
  assign blocked = (state_q != IFS_RUNNING) | glob_now; // RL2 RL15 RL19 RL23
  assign gate_h_o = pwm_h_i & ~pwm_l_i & {3{~blocked}}; // RL1 RL20
  assign gate_l_o = pwm_l_i & ~pwm_h_i & {3{~blocked}}; // RL1 RL20

  // ----------------------------------------------------------------
  // blink timers and leds
  // ----------------------------------------------------------------
  logic [31:0] slow_q, slow_d, fast_q, fast_d;
  logic sph_q, sph_d, fph_q, fph_d, warn_only;
  ifs_led_s [2:0] leg_led_q, leg_led_d;
  ifs_led_s sys_led_q, sys_led_d;

  always_comb begin
    slow_d = slow_q + 32'h0000_0001;
    fast_d = fast_q + 32'h0000_0001;
    sph_d = sph_q;
    fph_d = fph_q;
    if (slow_q >= SLOW_CYC - 1) begin
      slow_d = 32'h0000_0000;
      sph_d = ~sph_q;
    end
    if (fast_q >= FAST_CYC - 1) begin
      fast_d = 32'h0000_0000;
      fph_d = ~fph_q;
    end
  end

  assign warn_only = |(lat_q & WARN) && !(|(lat_q & ~WARN));

  always_comb begin
    logic bus_ov, enc_warn;
    bus_ov = lat_q[`IFS_F_OV] | lat_q[`IFS_LEG_W + `IFS_F_OV] |
             lat_q[2 * `IFS_LEG_W + `IFS_F_OV];
    enc_warn = |lat_q[`IFS_F_ENC + 2 : `IFS_F_ENC];
    for (int l = 0; l < 3; l++) begin
      leg_led_d[l] = '{red: 1'b0, green: 1'b1};
      if (lat_q[l * `IFS_LEG_W + `IFS_F_DESAT] || lat_q[l * `IFS_LEG_W + `IFS_F_SHOOT]) begin
        leg_led_d[l] = '{red: fph_q, green: 1'b0};
      end else if (lat_q[l * `IFS_LEG_W + `IFS_F_OC]) begin
        leg_led_d[l] = '{red: sph_q, green: 1'b0};
      end else if (lat_q[l * `IFS_LEG_W + `IFS_F_SUP]) begin
        leg_led_d[l] = '{red: 1'b1, green: 1'b0};
      end else if (lat_q[l * `IFS_LEG_W + `IFS_F_OT] || lat_q[l * `IFS_LEG_W + `IFS_F_FAN]) begin
        leg_led_d[l] = '{red: sph_q, green: sph_q}; // RL17
      end
    end
    // converter-wide events override the per-module view
    if (lat_q[`IFS_F_ENC + 3]) begin
      leg_led_d = {3{ifs_led_s'({fph_q, 1'b0})}}; // RL21
    end else if (bus_ov) begin
      leg_led_d = {3{ifs_led_s'({sph_q, 1'b0})}}; // RL21
    end else if (enc_warn) begin
      leg_led_d = {3{ifs_led_s'({sph_q, sph_q})}}; // RL21 RL17
    end
    sys_led_d = '{red: 1'b0, green: 1'b0};
    if (!code_running_i) begin
      sys_led_d = '{red: 1'b0, green: 1'b0};
    end else if (syncsel_q) begin
      sys_led_d = sync_led_i; // RL22
    end else if (state_q == IFS_FAULT) begin
      sys_led_d = '{red: 1'b1, green: warn_only}; // RL22 RL17
    end else if (state_q == IFS_BLOCKED) begin
      sys_led_d = '{red: 1'b0, green: sph_q}; // RL22
    end else begin
      sys_led_d = '{red: 1'b0, green: 1'b1}; // RL22
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_q <= 32'h0000_0000;
      fast_q <= 32'h0000_0000;
      sph_q <= 1'b0;
      fph_q <= 1'b0;
      leg_led_q <= '0;
      sys_led_q <= '0;
    end else if (ce_i) begin
      slow_q <= slow_d;
      fast_q <= fast_d;
      sph_q <= sph_d;
      fph_q <= fph_d;
      leg_led_q <= leg_led_d;
      sys_led_q <= sys_led_d;
    end
  end

  assign leg_led_o = leg_led_q;
  assign sys_led_o = sys_led_q;

  // ----------------------------------------------------------------
  // wishbone registers
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic req, wr;
  logic [15:0] imax_lo_q_d, imax_hi_q_d, vdcmax_lo_q_d, vdcmax_hi_q_d;

  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i;
  assign wr_ctrl = wr && adr_i == `IFS_REG_CTRL;

  always_comb begin
    ack_d = req;
    rd_d = rd_q;
    imax_lo_q_d = imax_lo_q;
    imax_hi_q_d = imax_hi_q;
    vdcmax_lo_q_d = vdcmax_lo_q;
    vdcmax_hi_q_d = vdcmax_hi_q;
    if (req) begin
      case (adr_i)
        `IFS_REG_CTRL: rd_d = {30'h0, syncsel_q, en_q};
        `IFS_REG_STATUS: rd_d = {28'h0, warn_only, glob_now, state_q};
        `IFS_REG_FAULTS: rd_d = {3'h0, lat_q};
        `IFS_REG_SOA: rd_d = {24'h0, raw[`IFS_F_SOA +: 4], lat_q[`IFS_F_SOA +: 4]}; // RL14
        `IFS_REG_FSW: rd_d = {16'h0, fsw_q};
        `IFS_REG_IMAX_LO: rd_d = {16'h0, imax_lo_q};
        `IFS_REG_IMAX_HI: rd_d = {16'h0, imax_hi_q};
        `IFS_REG_VDCMAX_LO: rd_d = {16'h0, vdcmax_lo_q};
        `IFS_REG_VDCMAX_HI: rd_d = {16'h0, vdcmax_hi_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
    if (wr && sel_i[1:0] == 2'h3) begin
      case (adr_i)
        `IFS_REG_IMAX_LO: imax_lo_q_d = dat_i[15:0];
        `IFS_REG_IMAX_HI: imax_hi_q_d = dat_i[15:0];
        `IFS_REG_VDCMAX_LO: vdcmax_lo_q_d = dat_i[15:0];
        `IFS_REG_VDCMAX_HI: vdcmax_hi_q_d = dat_i[15:0];
        default: ;
      endcase
    end
  end


  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      imax_lo_q <= `IFS_IMAX_RST;
      imax_hi_q <= `IFS_IMAX_RST;
      vdcmax_lo_q <= `IFS_VDCMAX_RST;
      vdcmax_hi_q <= `IFS_VDCMAX_RST;
    end else if (ce_i) begin
      ack_q <= ack_d;
      rd_q <= rd_d;
      imax_lo_q <= imax_lo_q_d;
      imax_hi_q <= imax_hi_q_d;
      vdcmax_lo_q <= vdcmax_lo_q_d;
      vdcmax_hi_q <= vdcmax_hi_q_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rd_q;
endmodule // ifs_supervisor
`default_nettype wire

// ### inc/ifs_consts.svh
/*
 * Offsets, field positions, thresholds and timing counts of the
 * inverter fault supervisor.
 * Assumes a 20 MHz clock and the measurement scaling given beside each
 * threshold.
 */
`ifndef IFS_CONSTS_SVH
`define IFS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IFS_REG_CTRL      8'h00
`define IFS_REG_STATUS    8'h04
`define IFS_REG_FAULTS    8'h08
`define IFS_REG_SOA       8'h0C
`define IFS_REG_FSW       8'h10
`define IFS_REG_IMAX_LO   8'h14
`define IFS_REG_IMAX_HI   8'h18
`define IFS_REG_VDCMAX_LO 8'h1C
`define IFS_REG_VDCMAX_HI 8'h20

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define IFS_CTRL_EN       0
`define IFS_CTRL_SYNCSEL  1
`define IFS_NFLT          29
`define IFS_LEG_W         7
`define IFS_F_OV          0
`define IFS_F_OC          1
`define IFS_F_DESAT       2
`define IFS_F_SUP         3
`define IFS_F_OT          4
`define IFS_F_FAN         5
`define IFS_F_SHOOT       6
`define IFS_F_ENC         21
`define IFS_F_SOA         25
`define IFS_WARN_MASK     29'h0EC1830

// ----------------------------------------------------------------
// thresholds (vdc 1 V, current 0.1 A, temp 1 C, rails/vds 10 mV,
// common-mode rms 10 mA)
// ----------------------------------------------------------------
`define IFS_VDC_MAX       16'h0352
`define IFS_IM_MAX        16'h0226
`define IFS_TEMP_MAX      16'h0050
`define IFS_VDS_MAX       16'h0118
`define IFS_V5_MIN        16'h01C2
`define IFS_V5_MAX        16'h0226
`define IFS_V12_MIN       16'h044C
`define IFS_V12_MAX       16'h0514
`define IFS_ENC_TEMP_MAX  16'h0078
`define IFS_IDM_MAX       16'h0028
`define IFS_ICM_MAX       16'h008C
`define IFS_FSW_KNEE      16'h0032
`define IFS_IMAX_RST      16'h0140
`define IFS_VDCMAX_RST    16'h0320

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IFS_CLK_HZ        20000000
`define IFS_WARN_MS       1000
`define IFS_WARN_CYC      (`IFS_WARN_MS * (`IFS_CLK_HZ / 1000))
`define IFS_TACH_MS       100
`define IFS_TACH_CYC      (`IFS_TACH_MS * (`IFS_CLK_HZ / 1000))
`define IFS_FSW_MS        1
`define IFS_FSW_CYC       (`IFS_FSW_MS * (`IFS_CLK_HZ / 1000))
`define IFS_SLOW_MS       250
`define IFS_SLOW_CYC      (`IFS_SLOW_MS * (`IFS_CLK_HZ / 1000))
`define IFS_FAST_MS       50
`define IFS_FAST_CYC      (`IFS_FAST_MS * (`IFS_CLK_HZ / 1000))

`endif

// ### inc/ifs_pkg.sv
/*
 * Types of the inverter fault supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ifs_pkg;
  typedef enum logic [1:0] {
    IFS_BLOCKED,
    IFS_RUNNING,
    IFS_FAULT
  } ifs_state_e;

  typedef struct packed {
    logic [15:0] vdc;
    logic signed [15:0] im;
    logic [15:0] temp;
    logic [15:0] vds_h;
    logic [15:0] vds_l;
    logic [15:0] v5;
    logic [15:0] v12;
  } ifs_leg_meas_s;

  typedef struct packed {
    logic red;
    logic green;
  } ifs_led_s;
endpackage

// ### dv/ifs_fan_model.sv
/* fan tachometer model of the three legs and the rear fan.
   assumes it shares clk_i with the supervisor */
`timescale 1ns/1ps
`default_nettype none
module ifs_fan_model (
  // clock
  input wire logic clk_i,
  // control
  input wire logic [3:0] stop_i,
  // tach lines
  output logic [3:0] tach_o
);
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    cnt_q <= cnt_d;
  end
  // a stalled fan leaves its line low, no edges at all
  assign tach_o = {4{cnt_q[3]}} & ~stop_i;
endmodule // ifs_fan_model
`default_nettype wire

// ### dv/ifs_supervisor_props.sv
/* properties of the fault supervisor ports.
   assumes ce_i held high and tach edges every few cycles */
`timescale 1ns/1ps
`default_nettype none
module ifs_supervisor_props
  import ifs_pkg::*;
(
  // clock, reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // gating
  input wire logic [2:0] pwm_h_i,
  input wire logic [2:0] pwm_l_i,
  input wire logic [2:0] gate_h_o,
  input wire logic [2:0] gate_l_o,
  // faults
  input wire ifs_pkg::ifs_leg_meas_s [2:0] meas_i,
  input wire logic signed [15:0] idr_dm_i,
  input wire logic interlock_fault_i,
  input wire logic global_fault_o
);
  // ---------------------------
  // properties
  // ---------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_leg_both_on: assert property (((pwm_h_i & pwm_l_i) & (gate_h_o | gate_l_o)) == 3'h0)
    else $error("gate on under both commands");
  a_fault_blocks: assert property (global_fault_o |-> (gate_h_o | gate_l_o) == 3'h0)
    else $error("gate on during fault");
  a_gate_cause: assert property (((gate_h_o & ~pwm_h_i) | (gate_l_o & ~pwm_l_i)) == 3'h0)
    else $error("gate on without command");
  a_bus_ov: assert property (meas_i[0].vdc > 16'h0352 |-> ##[0:1] global_fault_o)
    else $error("no fault on bus overvoltage");
  a_leg_oc: assert property ($signed(meas_i[2].im) < -16'sh0226 |-> ##[0:1] global_fault_o)
    else $error("no fault on overcurrent");
  a_rail_low: assert property (meas_i[1].v5 < 16'h01C2 |-> ##[0:1] global_fault_o)
    else $error("no fault on low rail");
  a_damp_oc: assert property (idr_dm_i > 16'sh0028 |-> ##[0:1] global_fault_o)
    else $error("no fault on damping current");
  a_ilk_fault: assert property (interlock_fault_i [*4] |-> global_fault_o)
    else $error("no fault on interlock");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  c_fault: cover property ($rose(global_fault_o));
  c_gate: cover property (gate_h_o != 3'h0);
  c_ack: cover property (ack_o);
endmodule // ifs_supervisor_props
`default_nettype wire

// ### dv/tb_ifs_supervisor.sv
/* bench of the fault supervisor with its fan model.
   assumes the supervisor, the fan model and the checker */
`timescale 1ns/1ps
`default_nettype none
`include "ifs_consts.svh"
module tb_ifs_supervisor;
  import ifs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] pwm_h = 3'h0;
  logic [2:0] pwm_l = 3'h0;
  logic [2:0] gate_h_o;
  logic [2:0] gate_l_o;
  ifs_leg_meas_s [2:0] meas;
  logic [15:0] enc_t = 16'h0028;
  logic signed [15:0] idr_dm = 16'sh0000;
  logic [3:0] tach;
  logic [3:0] stop = 4'h0;
  logic ilk = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic [15:0] icm = 16'h0000;
  logic sens = 1'b1;
  logic run_code = 1'b1;
  ifs_led_s sync_led = '0;
  logic glob;
  ifs_led_s [2:0] leg_led;
  ifs_led_s sys_led;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [31:0] rs = 32'hD500;
  logic [31:0] bits [7] = '{32'h1, 32'h8000, 32'h400, 32'h8, 32'h8000000, 32'h1000000,
                            32'h10000000};
  int n_fail = 0;
  int total_checks = 0;
  ifs_supervisor #(.WARN_CYC(20), .TACH_CYC(50), .FSW_CYC(100), .SLOW_CYC(8), .FAST_CYC(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .pwm_h_i(pwm_h), .pwm_l_i(pwm_l), .gate_h_o(gate_h_o), .gate_l_o(gate_l_o),
    .meas_i(meas), .enc_temp_i(enc_t), .idr_dm_i(idr_dm), .idr_cm_rms_i(icm),
    .tach_i(tach), .sensor_present_i(sens), .interlock_fault_i(ilk), .clear_btn_i(clr),
    .code_running_i(run_code), .sync_led_i(sync_led), .global_fault_o(glob),
    .leg_led_o(leg_led), .sys_led_o(sys_led));
  ifs_fan_model fans (.clk_i(clk_i), .stop_i(stop), .tach_o(tach));
  // ---------------------------
  // tasks
  // ---------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task results;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [31:0] m, input logic [31:0] e);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    eq.push_back(e);
    mq.push_back(w ? 32'h0 : m);
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    if (ack_o !== 1'b1) begin
      n_fail++;
      results();
    end
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task press;
    clr <= 1'b1;
    repeat (4) @(posedge clk_i);
    clr <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task pwm_run(input int n, input logic run);
    for (int i = 0; i < n; i++) begin
      rs = xs(rs);
      pwm_h <= rs[2:0];
      pwm_l <= rs[5:3] & ~rs[2:0];
      @(posedge clk_i);
      chk("gate_h", run ? pwm_h : 3'h0, gate_h_o);
      chk("gate_l", run ? pwm_l : 3'h0, gate_l_o);
    end
  endtask
  task cond(input int k, input logic on);
    case (k)
      0: meas[0].vdc <= on ? 16'h0353 : 16'h02BC;
      1: meas[2].im <= on ? -16'sh0227 : 16'sh0064;
      2: meas[1].v5 <= on ? 16'h01C1 : 16'h01F4;
      3: meas[0].v12 <= on ? 16'h0515 : 16'h04B0;
      4: idr_dm <= on ? 16'sh0029 : 16'sh0000;
      6: icm <= on ? 16'h008D : 16'h0000;
      default: ilk <= on;
    endcase
  endtask
  // ---------------------------
  // stimulus and scoreboard
  // ---------------------------
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && eq.size() > 0) chk("dat_o", eq.pop_front(), dat_o & mq.pop_front());
  end
  initial begin
    for (int l = 0; l < 3; l++) meas[l] = '{16'h02BC, 16'sh0064, 16'h0028, 0, 0, 16'h01F4, 16'h04B0};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `IFS_REG_CTRL, 0, 32'h3, 32'h0);
    wb(0, `IFS_REG_IMAX_LO, 0, '1, 32'h140);
    wb(0, `IFS_REG_VDCMAX_LO, 0, '1, 32'h320);
    wb(0, 8'hFC, 0, '1, 32'h0);
    pwm_run(8, 1'b0);
    wb(1, `IFS_REG_CTRL, 32'h1, 0, 0);
    wb(0, `IFS_REG_STATUS, 0, 32'h3, 32'h1);
    pwm_run(20, 1'b1);
    pwm_h <= 3'h2;
    pwm_l <= 3'h2;
    @(posedge clk_i);
    chk("gates", 32'h0, {gate_h_o, gate_l_o});
    chk("glob", 32'h1, glob);
    pwm_h <= 3'h0;
    pwm_l <= 3'h0;
    wb(0, `IFS_REG_STATUS, 0, 32'h3, 32'h2);
    press;
    wb(0, `IFS_REG_STATUS, 0, 32'h3, 32'h0);
    for (int k = 0; k < 7; k++) begin
      cond(k, 1'b1);
      repeat (4) @(posedge clk_i);
      chk("glob", 32'h1, glob);
      wb(0, `IFS_REG_FAULTS, 0, bits[k], bits[k]);
      if (k == 5) begin
        press;
        wb(0, `IFS_REG_STATUS, 0, 32'h3, 32'h2);
      end
      cond(k, 1'b0);
      repeat (4) @(posedge clk_i);
      press;
      wb(0, `IFS_REG_FAULTS, 0, '1, 32'h0);
    end
    enc_t <= 16'h0079;
    sens <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("glob", 32'h0, glob);
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("glob", 32'h0, glob);
    ce <= 1'b1;
    repeat (25) @(posedge clk_i);
    chk("glob", 32'h1, glob);
    chk("sys_led", 32'h3, 32'(sys_led));
    wb(0, `IFS_REG_FAULTS, 0, 32'h600000, 32'h600000);
    run_code <= 1'b0;
    sync_led <= 2'h1;
    wb(1, `IFS_REG_CTRL, 32'h2, 0, 0);
    chk("sys_led", 32'h0, 32'(sys_led));
    run_code <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("sys_led", 32'h1, 32'(sys_led));
    wb(1, `IFS_REG_CTRL, 32'h0, 0, 0);
    enc_t <= 16'h0028;
    sens <= 1'b1;
    press;
    wb(0, `IFS_REG_STATUS, 0, 32'h3, 32'h0);
    stop <= 4'h1;
    repeat (100) @(posedge clk_i);
    wb(0, `IFS_REG_FAULTS, 0, 32'h20, 32'h20);
    stop <= 4'h0;
    repeat (40) @(posedge clk_i);
    press;
    wb(0, `IFS_REG_FAULTS, 0, '1, 32'h0);
    results();
  end
endmodule // tb_ifs_supervisor
bind ifs_supervisor ifs_supervisor_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .pwm_h_i(pwm_h_i), .pwm_l_i(pwm_l_i), .gate_h_o(gate_h_o), .gate_l_o(gate_l_o),
  .meas_i(meas_i), .idr_dm_i(idr_dm_i), .interlock_fault_i(interlock_fault_i),
  .global_fault_o(global_fault_o));
`default_nettype wire
